// ===== rtl/fmcfg_regs.sv
// Purpose: Seek, band, volume, softmute and audio high-Z configuration registers
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Seek settings latch at op start; audio controls follow registers directly
//
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Seek rejects channels with strength below the level threshold.
// - Band field picks 87.5-108, 76-108 or 76-90 MHz; 11 reserved.
// - Spacing field picks 200, 100 or 50 kHz steps.
// - Volume 0 mutes; 1..15 span -28 to 0 dBFS in 2 dB steps.
// - Extended attenuation adds 30 dB, giving -58 to -30 dBFS.
// - Softmute rate 00 fastest through 11 slowest.
// - Softmute depth 00..11 gives 16, 14, 12, 10 dB.
// - SNR threshold 0 disables; 1 minimum, 15 maximum.
// - Impulse threshold 0 disables; 1 most stops, 15 fewest.
// - High-Z enable biases both audio outputs at half I/O supply.
// - High-Z takes effect only when powered down with I/O supply.
// - Test register resets to 0100; the other two reset to zero.
// - Frequency is spacing times channel plus band base.
// ----------------------------------------------------------------------------
//
// Chosen here: the address-and-strobe port.
`default_nettype none
`include "fmcfg_defs.svh"

module fmcfg_regs
  import fmcfg_pkg::*;
#(
  parameter int CHANNEL_NUMBER_W = 10
) (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [15:0]       reg_rdata_o,
  input  wire logic              op_start_i,
  input  wire logic [CHANNEL_NUMBER_W-1:0] channel_number_i,
  input  wire logic [7:0]        channel_level_i,
  input  wire logic [3:0]        channel_snr_i,
  input  wire logic [3:0]        channel_impulses_i,
  input  wire logic              powered_down_i,
  input  wire logic              io_supply_ok_i,
  output fmcfg_seek_t            seek_cfg_o,
  output logic                   seek_valid_o,
  output logic      [16:0]       tuned_khz_o,
  output fmcfg_audio_t           audio_o,
  output logic                   left_audio_out_o,
  output logic                   right_audio_out_o
);

  initial begin
    if (CHANNEL_NUMBER_W < 1 || CHANNEL_NUMBER_W > 10) begin
      $error("CHANNEL_NUMBER_W out of range");
    end
  end

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  // A 200 kHz step needs eight bits; seven would wrap it to 72
  function automatic logic [7:0] step_of(input logic [1:0] sp);
    unique case (sp)
      2'b00:   step_of = 8'd200;
      2'b01:   step_of = 8'd100;
      2'b10:   step_of = 8'd50;
      default: step_of = 8'd50;
    endcase
  endfunction : step_of

  function automatic logic [16:0] base_of(input fmcfg_band_t b);
    base_of = (b == FMCFG_BAND_WIDE) ? `FMCFG_BASE_WIDE_KHZ : `FMCFG_BASE_JAPAN_KHZ;
  endfunction : base_of

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  fmcfg_sbv_t  sbv, next_sbv;
  fmcfg_smq_t  smq, next_smq;
  logic [15:0] aht, next_aht;
  logic [15:0] next_rdata;

  always_comb begin
    next_sbv   = sbv;
    next_smq   = smq;
    next_aht   = aht;
    next_rdata = 16'h0000;
    if (reg_write_i) begin
      unique case (reg_addr_i)
        `FMCFG_OFS_SBV: next_sbv = fmcfg_sbv_t'(reg_wdata_i);
        `FMCFG_OFS_SMQ: next_smq = fmcfg_smq_t'(reg_wdata_i);
        `FMCFG_OFS_AHT: next_aht = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_read_i) begin
      unique case (reg_addr_i)
        `FMCFG_OFS_SBV: next_rdata = 16'(sbv);
        `FMCFG_OFS_SMQ: next_rdata = 16'(smq);
        `FMCFG_OFS_AHT: next_rdata = aht;
        `FMCFG_OFS_OPS: next_rdata = {14'h0000, io_supply_ok_i, powered_down_i};
        default:        next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sbv         <= fmcfg_sbv_t'(`FMCFG_RST_SBV);
      smq         <= fmcfg_smq_t'(`FMCFG_RST_SMQ);
      aht         <= `FMCFG_RST_AHT;
      reg_rdata_o <= 16'h0000;
    end else begin
      sbv         <= next_sbv;
      smq         <= next_smq;
      aht         <= next_aht;
      reg_rdata_o <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Seek settings, latched at op start
  // --------------------------------------------------------------------------
  fmcfg_seek_t next_seek;
  logic        next_valid;
  logic [16:0] next_khz;
  logic [16:0] channel_number_khz;

  always_comb begin
    next_seek = seek_cfg_o;
    if (op_start_i) begin
      next_seek.seek_level_threshold   = sbv.seek_level_threshold;
      next_seek.seek_snr_threshold     = smq.seek_snr_threshold;
      next_seek.seek_impulse_threshold = smq.seek_impulse_threshold;
      next_seek.base_khz               = base_of(sbv.band);
      next_seek.step_khz               = step_of(sbv.spacing);
      next_seek.band_valid             = (sbv.band != FMCFG_BAND_RSVD);
    end
    next_valid = seek_cfg_o.band_valid
               && (channel_level_i >= seek_cfg_o.seek_level_threshold)
               && ((seek_cfg_o.seek_snr_threshold == 4'h0)
                   || (channel_snr_i >= seek_cfg_o.seek_snr_threshold))
               && ((seek_cfg_o.seek_impulse_threshold == 4'h0)
                   || ((5'd16 - 5'(seek_cfg_o.seek_impulse_threshold))
                       > 5'(channel_impulses_i)));
    channel_number_khz = 17'(seek_cfg_o.step_khz * 17'(channel_number_i));
    next_khz = 17'(seek_cfg_o.base_khz + channel_number_khz);
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      seek_cfg_o   <= '0;
      seek_valid_o <= 1'b0;
      tuned_khz_o  <= 17'h00000;
    end else begin
      seek_cfg_o   <= next_seek;
      seek_valid_o <= next_valid;
      tuned_khz_o  <= next_khz;
    end
  end

  // --------------------------------------------------------------------------
  // Audio controls
  // --------------------------------------------------------------------------
  fmcfg_audio_t next_audio;
  logic         next_hiz;
  logic [7:0]   vol_att;

  always_comb begin
    vol_att                = 8'({4'h0, 4'hf - sbv.volume} << 1);
    next_audio.mute        = (sbv.volume == 4'h0);
    next_audio.atten_db    = smq.extended_attenuation_enable
                           ? 8'(vol_att + `FMCFG_EXT_ATT_DB) : vol_att;
    next_audio.softmute_rate = smq.softmute_rate;
    next_audio.softmute_db = 5'(5'd16 - 5'({smq.softmute_depth, 1'b0}));
    next_hiz               = aht[`FMCFG_AHT_HIZ_BIT] && powered_down_i
                           && io_supply_ok_i;
    next_audio.audio_highz = next_hiz;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      audio_o           <= '0;
      left_audio_out_o  <= 1'b0;
      right_audio_out_o <= 1'b0;
    end else begin
      audio_o           <= next_audio;
      left_audio_out_o  <= next_hiz;
      right_audio_out_o <= next_hiz;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  level_reject_a: assert property ((seek_cfg_o.seek_level_threshold > channel_level_i)
                                   |=> !seek_valid_o)
    else $error("weak channel accepted");
  band_reserved_a: assert property (!seek_cfg_o.band_valid |=> !seek_valid_o)
    else $error("reserved band accepted");
  step_decode_a: assert property (op_start_i && sbv.spacing == 2'b01
                                  |=> seek_cfg_o.step_khz == 8'd100)
    else $error("spacing step wrong");
  step_wide_a: assert property (op_start_i && sbv.spacing == 2'b00
                                |=> seek_cfg_o.step_khz == 8'd200)
    else $error("wide spacing step wrong");
  step_fine_a: assert property (op_start_i && sbv.spacing == 2'b10
                                |=> seek_cfg_o.step_khz == 8'd50)
    else $error("fine spacing step wrong");
  band_wide_a: assert property (op_start_i && sbv.band == FMCFG_BAND_WIDE
                                |=> seek_cfg_o.base_khz == 17'd87500)
    else $error("wide band base wrong");
  band_japan_a: assert property (op_start_i && sbv.band == FMCFG_BAND_JAPAN
                                 |=> seek_cfg_o.base_khz == 17'd76000)
    else $error("japan band base wrong");
  tune_freq_a: assert property (seek_cfg_o.base_khz == 17'd87500
                                && seek_cfg_o.step_khz == 8'd200
                                && 17'(channel_number_i) == 17'd10
                                |=> tuned_khz_o == 17'd89500)
    else $error("tuned frequency wrong");
  vol_mute_a: assert property (reg_write_i && reg_addr_i == `FMCFG_OFS_SBV
                               && reg_wdata_i[3:0] == 4'h0 |-> ##2 audio_o.mute)
    else $error("volume zero not muted");
  vol_ext_a: assert property (smq.extended_attenuation_enable && sbv.volume == 4'hf
                              |=> audio_o.atten_db == 8'd30)
    else $error("extended attenuation wrong");
  ext_low_a: assert property (smq.extended_attenuation_enable && sbv.volume == 4'h1
                              |=> audio_o.atten_db == 8'd58)
    else $error("extended low volume wrong");
  vol_full_a: assert property (!smq.extended_attenuation_enable && sbv.volume == 4'hf
                               |=> audio_o.atten_db == 8'd0)
    else $error("full volume attenuated");
  vol_low_a: assert property (!smq.extended_attenuation_enable && sbv.volume == 4'h1
                              |=> audio_o.atten_db == 8'd28)
    else $error("lowest volume wrong");
  rate_map_a: assert property (1'b1 |=> audio_o.softmute_rate == $past(smq.softmute_rate))
    else $error("softmute rate wrong");
  depth_zero_a: assert property (smq.softmute_depth == 2'b00
                                 |=> audio_o.softmute_db == 5'd16)
    else $error("softmute depth 16 wrong");
  depth_one_a: assert property (smq.softmute_depth == 2'b01
                                |=> audio_o.softmute_db == 5'd14)
    else $error("softmute depth 14 wrong");
  depth_two_a: assert property (smq.softmute_depth == 2'b10
                                |=> audio_o.softmute_db == 5'd12)
    else $error("softmute depth 12 wrong");
  depth_map_a: assert property (smq.softmute_depth == 2'b11
                                |=> audio_o.softmute_db == 5'd10)
    else $error("softmute depth wrong");
  snr_reject_a: assert property (seek_cfg_o.seek_snr_threshold != 4'h0
                                 && channel_snr_i < seek_cfg_o.seek_snr_threshold
                                 |=> !seek_valid_o)
    else $error("low snr accepted");
  impulse_reject_a: assert property (seek_cfg_o.seek_impulse_threshold != 4'h0
                                     && (5'd16 - 5'(seek_cfg_o.seek_impulse_threshold))
                                        <= 5'(channel_impulses_i)
                                     |=> !seek_valid_o)
    else $error("noisy channel accepted");
  hiz_follow_a: assert property (aht[`FMCFG_AHT_HIZ_BIT] && powered_down_i && io_supply_ok_i
                                 |=> left_audio_out_o && right_audio_out_o)
    else $error("highz bias missing");
  hiz_off_a: assert property (!aht[`FMCFG_AHT_HIZ_BIT]
                              |=> !left_audio_out_o && !right_audio_out_o)
    else $error("highz without enable");
  test_write_a: assert property (reg_write_i && reg_addr_i == `FMCFG_OFS_AHT
                                 |=> aht == $past(reg_wdata_i))
    else $error("test register write lost");
  test_read_a: assert property (reg_read_i && reg_addr_i == `FMCFG_OFS_AHT
                                |=> reg_rdata_o == $past(aht))
    else $error("test register read wrong");
  rdata_idle_a: assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  hiz_gate_a: assert property (!powered_down_i || !io_supply_ok_i
                               |=> !left_audio_out_o && !right_audio_out_o)
    else $error("highz outside powerdown");
  rst_test_a: assert property ($fell(sys_rst_i) |-> aht == `FMCFG_RST_AHT
                               && 16'(sbv) == 16'h0000)
    else $error("reset values wrong");
  latch_hold_a: assert property (!op_start_i |=> $stable(seek_cfg_o))
    else $error("seek settings changed mid op");

  seek_ok_c: cover property (op_start_i ##[1:4] seek_valid_o);
  hiz_on_c:  cover property ($rose(left_audio_out_o));
  ext_vol_c: cover property (audio_o.atten_db == 8'd58);
  rsvd_band_c: cover property (op_start_i && sbv.band == FMCFG_BAND_RSVD);
  reject_c:  cover property ($fell(seek_valid_o));

endmodule : fmcfg_regs
`default_nettype wire

// ===== shared/fmcfg_defs.svh
// Purpose: Offsets, field positions, reset values and band bases of the tuner config bank
// Assumes: 16-bit registers, word-indexed plain register port
// Notes:   Included by the package and the design
`ifndef FMCFG_DEFS_SVH
`define FMCFG_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define FMCFG_OFS_SBV        4'h5
`define FMCFG_OFS_SMQ        4'h6
`define FMCFG_OFS_AHT        4'h7
`define FMCFG_OFS_OPS        4'h8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FMCFG_RST_SBV        16'h0000
`define FMCFG_RST_SMQ        16'h0000
`define FMCFG_RST_AHT        16'h0100
`define FMCFG_AHT_LOW_DOWN   14'h0100
`define FMCFG_AHT_LOW_UP     14'h3c04

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FMCFG_SMQ_RSVD_MASK  16'h0e00
`define FMCFG_AHT_RSVD_BIT   15
`define FMCFG_AHT_HIZ_BIT    14
`define FMCFG_EXTENDED_ATTENUATION_ENABLE_BIT     8
`define FMCFG_EXT_ATT_DB     8'd30

// ----------------------------------------------------------------------------
// Band bases in kHz
// ----------------------------------------------------------------------------
`define FMCFG_BASE_WIDE_KHZ  17'd87500
`define FMCFG_BASE_JAPAN_KHZ 17'd76000

`endif

// ===== shared/fmcfg_pkg.sv
// Purpose: Types of the tuner config bank
// Assumes: fmcfg_defs.svh supplies the numbers
// Notes:   Field layouts as packed structs
`default_nettype none
`include "fmcfg_defs.svh"
package fmcfg_pkg;

  // --------------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FMCFG_BAND_WIDE  = 2'b00,
    FMCFG_BAND_JWIDE = 2'b01,
    FMCFG_BAND_JAPAN = 2'b10,
    FMCFG_BAND_RSVD  = 2'b11
  } fmcfg_band_t;

  // --------------------------------------------------------------------------
  // Register layouts
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  seek_level_threshold;
    fmcfg_band_t band;
    logic [1:0]  spacing;
    logic [3:0]  volume;
  } fmcfg_sbv_t;

  typedef struct packed {
    logic [1:0] softmute_rate;
    logic [1:0] softmute_depth;
    logic [2:0] reserved;
    logic       extended_attenuation_enable;
    logic [3:0] seek_snr_threshold;
    logic [3:0] seek_impulse_threshold;
  } fmcfg_smq_t;

  // Settings latched at start of a seek or tune
  typedef struct packed {
    logic [7:0]  seek_level_threshold;
    logic [3:0]  seek_snr_threshold;
    logic [3:0]  seek_impulse_threshold;
    logic [16:0] base_khz;
    logic [7:0]  step_khz;
    logic        band_valid;
  } fmcfg_seek_t;

  // Audio output controls
  typedef struct packed {
    logic       mute;
    logic [7:0] atten_db;
    logic [1:0] softmute_rate;
    logic [4:0] softmute_db;
    logic       audio_highz;
  } fmcfg_audio_t;

endpackage : fmcfg_pkg
`default_nettype wire

// ===== testbench/fmcfg_regs_tb.sv
// Purpose: Self-checking bench of the tuner configuration register bank
// Assumes: Plain register port, read data in the cycle after the read strobe
// Notes:   Outputs are sampled 1 ns after an edge so that its updates have landed
`default_nettype none

module tb
  import fmcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic         clock_i, sys_rst_i, reg_write_i, reg_read_i, op_start_i;
  logic         powered_down_i, io_supply_ok_i, seek_valid_o, lo_o, ro_o;
  logic [3:0]   reg_addr_i, channel_snr_i, channel_impulses_i;
  logic [15:0]  reg_wdata_i, reg_rdata_o;
  logic [9:0]   channel_number_i;
  logic [7:0]   channel_level_i;
  logic [16:0]  tuned_khz_o;
  fmcfg_seek_t  seek_cfg_o;
  fmcfg_audio_t audio_o;
  int           bad_count, num_checks;

  fmcfg_regs fmcfg_regs_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .op_start_i(op_start_i),
    .channel_number_i(channel_number_i), .channel_level_i(channel_level_i),
    .channel_snr_i(channel_snr_i), .channel_impulses_i(channel_impulses_i),
    .powered_down_i(powered_down_i), .io_supply_ok_i(io_supply_ok_i),
    .seek_cfg_o(seek_cfg_o), .seek_valid_o(seek_valid_o), .tuned_khz_o(tuned_khz_o),
    .audio_o(audio_o), .left_audio_out_o(lo_o), .right_audio_out_o(ro_o)
  );

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1;
    chk("reg_rdata_o", {1'b0, exp}, {1'b0, reg_rdata_o});
  endtask : rd

  task automatic start_op();
    @(posedge clock_i);
    op_start_i <= 1'b1;
    @(posedge clock_i);
    op_start_i <= 1'b0;
    tick(2);
  endtask : start_op

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------------------
  // Clock, watchdog
  // --------------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Whole run is a few hundred cycles; this bound leaves a wide margin
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    logic [16:0] base, step;
    bad_count = 0; num_checks = 0;
    sys_rst_i = 1'b1; reg_write_i = 1'b0; reg_read_i = 1'b0; op_start_i = 1'b0;
    reg_addr_i = 4'h0; reg_wdata_i = 16'h0000; channel_number_i = 10'h00a;
    channel_level_i = 8'h00; channel_snr_i = 4'h0; channel_impulses_i = 4'h0;
    powered_down_i = 1'b1; io_supply_ok_i = 1'b1;
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(4'h5, 16'h0000);
    rd(4'h6, 16'h0000);
    rd(4'h7, 16'h0100);
    rd(4'h3, 16'h0000);
    wr(4'h8, 16'hffff);
    rd(4'h8, 16'h0003);
    // Volume with and without extended attenuation
    for (int e = 0; e < 2; e++) begin
      wr(4'h6, 16'(e) << 8);
      for (int v = 0; v < 16; v++) begin
        wr(4'h5, 16'(v));
        tick(2);
        chk("mute", 17'(v == 0), 17'(audio_o.mute));
        if (v != 0) chk("atten_db", 17'(2 * (15 - v) + 30 * e), 17'(audio_o.atten_db));
      end
    end
    // Softmute rate and depth codes
    for (int i = 0; i < 4; i++) begin
      wr(4'h6, 16'(i) << 14 | 16'(3 - i) << 12);
      tick(2);
      chk("softmute_rate", 17'(i), 17'(audio_o.softmute_rate));
      chk("softmute_db", 17'(16 - 2 * (3 - i)), 17'(audio_o.softmute_db));
    end
    // Band and spacing, latched at operation start
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 4; s++) begin
        wr(4'h5, 16'(b) << 6 | 16'(s) << 4);
        start_op();
        base = (b == 0) ? 17'd87500 : 17'd76000;
        step = (s == 0) ? 17'd200 : (s == 1) ? 17'd100 : 17'd50;
        chk("band_valid", 17'(b != 3), 17'(seek_cfg_o.band_valid));
        if (b != 3) begin
          chk("base_khz", base, 17'(seek_cfg_o.base_khz));
          chk("step_khz", step, 17'(seek_cfg_o.step_khz));
          chk("tuned_khz", base + step * 17'd10, tuned_khz_o);
        end
      end
    end
    // Thresholds take effect only at the next operation start
    wr(4'h5, 16'h4000);
    wr(4'h6, 16'h0054);
    tick(2);
    chk("held level thr", 17'h0, 17'(seek_cfg_o.seek_level_threshold));
    start_op();
    chk("level thr", 17'h40, 17'(seek_cfg_o.seek_level_threshold));
    chk("snr thr", 17'h5, 17'(seek_cfg_o.seek_snr_threshold));
    chk("impulse thr", 17'h4, 17'(seek_cfg_o.seek_impulse_threshold));
    // Seek judgement at each threshold boundary
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        wr(4'h6, 16'h0000);
        start_op();
      end
      @(posedge clock_i);
      channel_level_i    <= (k == 1) ? 8'h3f : 8'h40;
      channel_snr_i      <= (k == 2) ? 4'h4 : (k == 4) ? 4'h0 : 4'h5;
      channel_impulses_i <= (k == 3) ? 4'hc : (k == 4) ? 4'hf : 4'hb;
      tick(2);
      chk("seek_valid", 17'(k == 0 || k == 4), 17'(seek_valid_o));
    end
    // High-Z only when powered down with I/O supply; low bits kept by read-back
    rd(4'h7, 16'h0100);
    wr(4'h7, 16'h4100);
    for (int p = 0; p < 3; p++) begin
      @(posedge clock_i);
      powered_down_i <= (p != 1);
      io_supply_ok_i <= (p != 2);
      tick(3);
      chk("audio_highz", 17'(p == 0), 17'(audio_o.audio_highz));
      chk("left_audio_out", 17'(p == 0), 17'(lo_o));
      chk("right_audio_out", 17'(p == 0), 17'(ro_o));
    end
    rd(4'h7, 16'h4100);
    give_verdict();
  end

endmodule : tb
`default_nettype wire
